// ==== rtl/adcc_top.v ====
// Purpose: Converter control with Wishbone register slave
// Assumes: Comparator input AN_CMP is high when analog level >= AN_DAC
// Notes:   One clock domain; all outputs registered
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"
module adcc_top #(
  parameter RC_HALF = `ADCC_RC_HALF_CYC
) (
  input  wire        REF_CLK,
  input  wire        RST,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [9:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  output reg         IRQ,
  input  wire [5:0]  PA_IN,
  output reg  [5:0]  PA_OUT,
  output reg  [5:0]  PA_OE_N,
  input  wire        CCP_TRIGGER,
  input  wire        AN_CMP,
  output reg  [2:0]  AN_CHANNEL,
  output reg  [7:0]  AN_DAC,
  output reg         AN_ON
);
  reg  [7:0]  irq_master_q;
  reg  [7:0]  enables_q;
  reg  [2:0]  pin_cfg_q;
  reg  [1:0]  clk_sel_q;
  reg         go_q;
  reg  [7:0]  result_q;
  reg         done_q;
  reg  [3:0]  ccp_mode_q;
  reg         tmr_run_q;
  reg  [4:0]  half_cnt_q;
  reg  [7:0]  trial_bit_q;
  reg  [7:0]  sar_q;
  reg  [7:0]  rd_data;
  wire [15:0] tmr_count;
  wire        half_tick;
  wire        bus_req;
  wire        wr_en;
  wire [7:0]  idx;
  wire [7:0]  wdat;
  wire        wr_ctrl;
  wire        sw_start;
  wire        trig_hit;
  wire        hw_start;
  wire        start;
  wire        decide;
  wire        finish;
  wire        cmp_eff;
  wire [2:0]  pin;
  wire [5:0]  amask;
  wire        done_clr;
  wire        abort;
  wire        wr_ccp;
  wire [5:0]  port_rd;
  wire [5:0]  pin_lvl;
  genvar      g;

  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  // Port bits that act as analog inputs for a pin function setting
  function [5:0] analog_mask;
    input [2:0] cfg;
    begin
      case (cfg)
        3'b000, 3'b001, 3'b010, 3'b011: analog_mask = 6'h2f;
        3'b100, 3'b101:                 analog_mask = 6'h0b;
        default:                        analog_mask = 6'h00;
      endcase
    end
  endfunction

  // Port bit that carries a channel; codes above four fall back to bit 0
  function [2:0] chan_pin;
    input [2:0] ch;
    begin
      case (ch)
        3'd1:    chan_pin = 3'd1;
        3'd2:    chan_pin = 3'd2;
        3'd3:    chan_pin = 3'd3;
        3'd4:    chan_pin = 3'd5;
        default: chan_pin = 3'd0;
      endcase
    end
  endfunction

  // Write strobe of one register; used by the control, trigger setup and flag-clear decodes below
  function reg_hit;
    input       en;
    input [7:0] at;
    input [7:0] want;
    begin
      reg_hit = en & (at == want);
    end
  endfunction

  assign bus_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr_en    = bus_req & WB_WE_I & WB_SEL_I[0];
  assign idx      = WB_ADR_I[9:2];
  assign wdat     = WB_DAT_I[7:0];
  assign wr_ctrl  = reg_hit(wr_en, idx, `ADCC_IDX_CTRL_MAIN);
  assign wr_ccp   = reg_hit(wr_en, idx, `ADCC_IDX_CCP_CTRL);
  assign done_clr = reg_hit(wr_en, idx, `ADCC_IDX_FLAGS_ONE)
                    & wdat[`ADCC_DONE_BIT];
  // Clearing the on bit beats a start or a completion in the same cycle
  assign abort    = wr_ctrl & ~wdat[`ADCC_CTRL_ON];

  // Start needs the converter already on; a write that also turns it
  // off wins, so the start is dropped
  assign sw_start = wr_ctrl & wdat[`ADCC_CTRL_GO] & AN_ON
                    & wdat[`ADCC_CTRL_ON]; // [RULE16]
  assign trig_hit = CCP_TRIGGER & (ccp_mode_q == `ADCC_TRIG_MODE);
  assign hw_start = trig_hit & AN_ON; // [RULE12] [RULE14]
  // Channel and direction bits are not consulted here
  assign start    = ~go_q & (sw_start | hw_start); // [RULE8]

  assign decide = go_q & half_tick & ~half_cnt_q[0]
                  & (half_cnt_q >= 5'd2)
                  & (half_cnt_q <= `ADCC_CONV_HALVES - 5'd3);
  assign finish = go_q & half_tick
                  & (half_cnt_q == `ADCC_CONV_HALVES - 5'd1); // [RULE1]

  assign pin   = chan_pin(AN_CHANNEL);
  assign amask = analog_mask(pin_cfg_q);
  // Per pin: analog-configured bits read low, output pins feed their latch
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_pin
      assign port_rd[g] = PA_IN[g] & ~amask[g]; // [RULE9]
      assign pin_lvl[g] = PA_OE_N[g] ? AN_CMP : PA_OUT[g]; // [RULE7]
    end
  endgenerate
  // Any input pin is taken as analog, whatever its digital setting
  assign cmp_eff = pin_lvl[pin]; // [RULE10]

  adcc_tad_gen #(
    .RC_HALF (RC_HALF)
  ) u_tad (
    .clk       (REF_CLK),
    .rst       (RST),
    .sel       (clk_sel_q),
    .restart   (start),
    .half_tick (half_tick)
  );

  adcc_timer16 u_tmr (
    .clk   (REF_CLK),
    .rst   (RST),
    .run   (tmr_run_q),
    .clear (trig_hit), // [RULE13] [RULE14]
    .count (tmr_count)
  );

  always @* begin
    case (idx)
      `ADCC_IDX_PORT_A:      rd_data = {2'b00, port_rd}; // [RULE9]
      `ADCC_IDX_IRQ_MASTER:  rd_data = irq_master_q;
      `ADCC_IDX_FLAGS_ONE:   rd_data = {1'b0, done_q, 6'h00};
      `ADCC_IDX_RESULT:      rd_data = result_q;
      `ADCC_IDX_CTRL_MAIN:   rd_data = {clk_sel_q, AN_CHANNEL, go_q,
                                        1'b0, AN_ON};
      `ADCC_IDX_CCP_CTRL:    rd_data = {3'b000, tmr_run_q, ccp_mode_q};
      `ADCC_IDX_TIMER_LO:    rd_data = tmr_count[7:0];
      `ADCC_IDX_TIMER_HI:    rd_data = tmr_count[15:8];
      `ADCC_IDX_PORT_A_DIR:  rd_data = {2'b00, PA_OE_N};
      `ADCC_IDX_ENABLES_ONE: rd_data = enables_q;
      `ADCC_IDX_PIN_CONFIG:  rd_data = {5'b00000, pin_cfg_q};
      default:               rd_data = 8'h00;
    endcase
  end

  // Single-wait slave: ack one cycle after the request, dropped next cycle
  always @(posedge REF_CLK) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_req && !WB_WE_I) begin
        WB_DAT_O <= {24'h000000, rd_data};
      end
    end
  end

  // Software-owned configuration
  always @(posedge REF_CLK) begin
    if (RST) begin
      PA_OUT       <= 6'h00;
      PA_OE_N      <= `ADCC_RST_DIR;
      irq_master_q <= `ADCC_RST_BYTE;
      enables_q    <= `ADCC_RST_BYTE;
      pin_cfg_q    <= 3'b000;
      clk_sel_q    <= 2'b00;
      AN_CHANNEL   <= 3'b000;
      AN_ON        <= 1'b0;
    end else if (wr_en) begin
      case (idx)
        `ADCC_IDX_PORT_A:      PA_OUT <= wdat[5:0];
        `ADCC_IDX_IRQ_MASTER:  irq_master_q <= wdat;
        `ADCC_IDX_PORT_A_DIR:  PA_OE_N <= wdat[5:0];
        `ADCC_IDX_ENABLES_ONE: enables_q <= wdat;
        `ADCC_IDX_PIN_CONFIG:  pin_cfg_q <= wdat[2:0];
        `ADCC_IDX_CTRL_MAIN: begin
          clk_sel_q  <= wdat[`ADCC_CTRL_CLKSEL_HI:`ADCC_CTRL_CLKSEL_LO];
          AN_CHANNEL <= wdat[`ADCC_CTRL_CHAN_HI:`ADCC_CTRL_CHAN_LO];
          AN_ON      <= wdat[`ADCC_CTRL_ON];
        end
        default: begin
        end
      endcase
    end
  end

  // Trigger setup sits apart: it never depends on the sequencer state
  always @(posedge REF_CLK) begin
    if (RST) begin
      ccp_mode_q <= 4'h0;
      tmr_run_q  <= 1'b0;
    end else if (wr_ccp) begin
      ccp_mode_q <= wdat[3:0];
      tmr_run_q  <= wdat[`ADCC_CCP_RUN_BIT];
    end
  end

  // Conversion sequencer: 19 half bit periods, eight bit decisions
  always @(posedge REF_CLK) begin
    if (RST) begin
      go_q        <= ST_IDLE;
      half_cnt_q  <= 5'd0;
      trial_bit_q <= 8'h00;
      sar_q       <= 8'h00;
      result_q    <= 8'h00;
      AN_DAC      <= 8'h00;
    end else if (abort) begin
      // Turning the converter off abandons a conversion in flight
      go_q        <= ST_IDLE;
      half_cnt_q  <= 5'd0;
      trial_bit_q <= 8'h00;
      AN_DAC      <= 8'h00;
    end else begin
      case (go_q)
        ST_IDLE: begin
          if (start) begin
            go_q        <= ST_CONV; // [RULE16] [RULE12]
            half_cnt_q  <= 5'd0;
            trial_bit_q <= 8'h80;
            sar_q       <= 8'h00;
            AN_DAC      <= 8'h80;
          end
        end
        ST_CONV: begin
          if (finish) begin
            go_q        <= ST_IDLE; // [RULE15]
            half_cnt_q  <= 5'd0;
            result_q    <= sar_q; // [RULE15]
            trial_bit_q <= 8'h00;
            AN_DAC      <= 8'h00;
          end else if (half_tick) begin
            half_cnt_q <= half_cnt_q + 5'd1; // [RULE1]
            if (decide) begin
              sar_q       <= cmp_eff ? (sar_q | trial_bit_q) : sar_q;
              trial_bit_q <= {1'b0, trial_bit_q[7:1]};
              AN_DAC      <= (cmp_eff ? (sar_q | trial_bit_q) : sar_q)
                             | {1'b0, trial_bit_q[7:1]};
            end
          end
        end
        default: begin
          go_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Done flag: completion in the same cycle as a clear keeps the flag set
  always @(posedge REF_CLK) begin
    if (RST) begin
      done_q <= 1'b0;
      IRQ    <= 1'b0;
    end else begin
      if (finish && !abort) begin
        done_q <= 1'b1; // [RULE15]
      end else if (done_clr) begin
        done_q <= 1'b0;
      end
      IRQ <= done_q & enables_q[`ADCC_DONE_BIT]
             & irq_master_q[`ADCC_GIE_BIT] & irq_master_q[`ADCC_PERIPHERAL_IRQ_ENABLE_BIT];
    end
  end
endmodule
`default_nettype wire

// ==== rtl/adcc_map.vh ====
// Purpose: Register map and timing constants of the converter control block
// Assumes: Register index = printed offset, byte address = 4 * index
// Notes:   Contract list below, tags appear in the design files
//
// Contract
// (RULE1) Conversion lasts 9.5 bit periods to done
// (RULE2) Clock select: 2, 8, 32 osc or RC
// (RULE3) Software keeps bit period at least 1.6 us
// (RULE4) RC bit period independent, about 4 us
// (RULE5) Above 1 MHz, RC clock for sleep only
// (RULE6) Software waits acquisition interval before start
// (RULE7) Output-configured pin converts its driven level
// (RULE8) Channel and direction never block conversions
// (RULE9) Analog-configured port bits read as zero
// (RULE10) Digital-input channel still converted as analog
// (RULE11) Software enables converter before setting start
// (RULE12) Trigger in mode 1011 with converter on starts
// (RULE13) Trigger clears the sixteen bit timer
// (RULE14) Converter off: trigger ignored, timer still cleared
// (RULE15) Completion loads result, clears start, sets flag
// (RULE16) Writing start with converter on begins conversion
// (RULE17) Software waits two bit periods before reacquiring
// (RULE18) Oscillator divider restarts at conversion start
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

`define ADCC_IDX_PORT_A      8'h05
`define ADCC_IDX_IRQ_MASTER  8'h0b
`define ADCC_IDX_FLAGS_ONE   8'h0c
`define ADCC_IDX_RESULT      8'h1e
`define ADCC_IDX_CTRL_MAIN   8'h1f
`define ADCC_IDX_CCP_CTRL    8'h20
`define ADCC_IDX_TIMER_LO    8'h21
`define ADCC_IDX_TIMER_HI    8'h22
`define ADCC_IDX_PORT_A_DIR  8'h85
`define ADCC_IDX_ENABLES_ONE 8'h8c
`define ADCC_IDX_PIN_CONFIG  8'h9f

`define ADCC_CTRL_CLKSEL_HI  7
`define ADCC_CTRL_CLKSEL_LO  6
`define ADCC_CTRL_CHAN_HI    5
`define ADCC_CTRL_CHAN_LO    3
`define ADCC_CTRL_GO         2
`define ADCC_CTRL_ON         0
`define ADCC_DONE_BIT        6
`define ADCC_GIE_BIT         7
`define ADCC_PERIPHERAL_IRQ_ENABLE_BIT        6
`define ADCC_CCP_RUN_BIT     4

`define ADCC_RST_DIR         6'h3f
`define ADCC_RST_BYTE        8'h00
`define ADCC_TRIG_MODE       4'hb

`define ADCC_CLK_NS          20
`define ADCC_RC_TAD_NS       4000
`define ADCC_RC_HALF_CYC     ((`ADCC_RC_TAD_NS / 2) / `ADCC_CLK_NS)
`define ADCC_HALF_2TOSC      5'd1
`define ADCC_HALF_8TOSC      5'd4
`define ADCC_HALF_32TOSC     5'd16
`define ADCC_CONV_HALVES     5'd19

`endif

// ==== rtl/adcc_tad_gen.v ====
// Purpose: Half bit-period tick generator for the converter
// Assumes: Oscillator period equals one REF_CLK period
// Notes:   RC source is modelled by a free-running divider
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"
module adcc_tad_gen #(
  parameter RC_HALF = `ADCC_RC_HALF_CYC
) (
  input  wire       clk,
  input  wire       rst,
  input  wire [1:0] sel,
  input  wire       restart,
  output wire       half_tick
);
  reg  [4:0]  osc_cnt_q;
  reg  [15:0] rc_cnt_q;
  reg  [4:0]  osc_lim;
  wire        osc_tick;
  wire        rc_tick;

  always @* begin
    case (sel)
      2'b00:   osc_lim = `ADCC_HALF_2TOSC; // [RULE2]
      2'b01:   osc_lim = `ADCC_HALF_8TOSC; // [RULE2]
      default: osc_lim = `ADCC_HALF_32TOSC; // [RULE2]
    endcase
  end

  assign osc_tick = (osc_cnt_q == osc_lim - 5'd1);
  assign rc_tick  = (rc_cnt_q == RC_HALF[15:0] - 16'd1);
  assign half_tick = (sel == 2'b11) ? rc_tick : osc_tick;

  always @(posedge clk) begin
    if (rst || restart || osc_tick) begin
      osc_cnt_q <= 5'd0; // [RULE18]
    end else begin
      osc_cnt_q <= osc_cnt_q + 5'd1;
    end
  end

  // RC divider ignores restart, as the real RC source runs on its own
  always @(posedge clk) begin
    if (rst || rc_tick) begin
      rc_cnt_q <= 16'd0; // [RULE4]
    end else begin
      rc_cnt_q <= rc_cnt_q + 16'd1;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/adcc_timer16.v ====
// Purpose: Sixteen bit timer cleared by the special event trigger
// Assumes: Counts REF_CLK cycles while run is high
// Notes:   Clear wins over counting
`timescale 1ns/1ps
`default_nettype none
module adcc_timer16 (
  input  wire        clk,
  input  wire        rst,
  input  wire        run,
  input  wire        clear,
  output reg  [15:0] count
);
  always @(posedge clk) begin
    if (rst || clear) begin
      count <= 16'h0000; // [RULE13]
    end else if (run) begin
      count <= count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/dummy_never_used_placeholder_removed.v ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verif/adcc_chk_properties.sv ====
// Purpose: Port checks of the converter control block
// Assumes: Byte address is four times the register index
// Notes:   Conversion timing is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module adcc_chk #(
  parameter RC_HALF = 3
) (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [9:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic [5:0]  PA_OE_N,
  input wire logic [2:0]  AN_CHANNEL,
  input wire logic        AN_ON
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  wire tk = WB_CYC_I & WB_STB_I & !WB_ACK_O;
  wire wr = tk & WB_WE_I & WB_SEL_I[0];
  wire wc = wr & (WB_ADR_I == 10'h07c);
  property p_ack; tk |=> WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_one; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_one: assert property (p_one) else $error("ack too long");
  property p_rst;
    disable iff (1'b0) RST |=> PA_OE_N == 6'h3f && !AN_ON;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_on; wc |=> AN_ON == $past(WB_DAT_I[0]); endproperty
  a_on: assert property (p_on) else $error("on bit");
  property p_ch; wc |=> AN_CHANNEL == $past(WB_DAT_I[5:3]); endproperty
  a_ch: assert property (p_ch) else $error("channel");
  property p_dir;
    wr & (WB_ADR_I == 10'h214) |=> PA_OE_N == $past(WB_DAT_I[5:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction");
  property p_hi; WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits");
  property p_unm;
    tk & !WB_WE_I & (WB_ADR_I == 10'h3fc) |=> WB_DAT_O == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  c_go: cover property (wc && WB_DAT_I[2]);
  c_rd: cover property (WB_ACK_O && !WB_WE_I);
  c_off: cover property (wc && !WB_DAT_I[0]);
endmodule
bind adcc_top adcc_chk #(.RC_HALF(RC_HALF)) adcc_chk_i (.REF_CLK, .RST,
  .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
  .WB_DAT_O, .WB_ACK_O, .PA_OE_N, .AN_CHANNEL, .AN_ON);
`default_nettype wire

// ==== verif/adcc_analog_src.sv ====
// Purpose: Analog pins and comparator facing the converter
// Assumes: Each channel level is an 8-bit code
// Notes:   Comparator toggles while off, so no stale level helps
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_src (
  input  wire logic        clk,
  input  wire logic        on,
  input  wire logic [2:0]  ch,
  input  wire logic [7:0]  dac,
  input  wire logic [5:0]  lat,
  input  wire logic [5:0]  oe_n,
  input  wire logic [39:0] lvl,
  output logic             cmp
);
  logic       tg = 1'b0;
  logic [2:0] idx;
  logic [2:0] pin;
  logic [7:0] v;
  always @(posedge clk) tg <= !tg;
  always_comb begin
    idx = (ch > 3'd4) ? 3'd0 : ch;
    pin = (ch == 3'd4) ? 3'd5 : idx;
    v = oe_n[pin] ? lvl[idx*8 +: 8] : {8{lat[pin]}};
    cmp = on ? (v >= dac) : tg;
  end
endmodule
`default_nettype wire

// ==== verif/adc_conversion_control_test.sv ====
// Purpose: Self-checking bench of the converter control block
// Assumes: Reads queue their expected byte, a monitor compares
// Notes:   RC half period shortened to 3 clocks
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module adc_conversion_control_test;
  logic REF_CLK = 0, RST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
  logic CCP_TRIGGER = 0, WB_ACK_O, IRQ, AN_CMP, AN_ON, ok;
  logic [9:0] WB_ADR_I = 0;
  logic [3:0] WB_SEL_I = 4'hf;
  logic [31:0] WB_DAT_I = 0, WB_DAT_O;
  logic [5:0] PA_IN, PA_OUT, PA_OE_N;
  logic [2:0] AN_CHANNEL;
  logic [7:0] AN_DAC, e;
  logic [39:0] lvl;
  logic [15:0] q[$];
  logic [7:0] cf[3] = '{8'h00, 8'h04, 8'h06};
  logic [5:0] mk[3] = '{6'h10, 6'h34, 6'h3f};
  int h[4] = '{1, 4, 16, 3};
  int fail_count = 0, check_count = 0, cyc_n = 0, t0, lo, c;
  adcc_top #(.RC_HALF(3)) adcc_top_i (.REF_CLK, .RST, .WB_CYC_I, .WB_STB_I,
    .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .IRQ,
    .PA_IN, .PA_OUT, .PA_OE_N, .CCP_TRIGGER, .AN_CMP, .AN_CHANNEL, .AN_DAC,
    .AN_ON);
  adcc_analog_src adcc_analog_src_i (.clk(REF_CLK), .on(AN_ON),
    .ch(AN_CHANNEL), .dac(AN_DAC), .lat(PA_OUT), .oe_n(PA_OE_N), .lvl,
    .cmp(AN_CMP));
  always #10 REF_CLK = !REF_CLK;
  always @(posedge REF_CLK) cyc_n <= cyc_n + 1;
  always @(posedge REF_CLK) begin
    if (WB_ACK_O && !WB_WE_I && q.size() > 0) begin
      `CHK($sformatf("reg%h", q[0][15:8]), q[0][7:0], WB_DAT_O)
      void'(q.pop_front());
    end
  end
  task automatic close_out();
    @(posedge REF_CLK);
    if (q.size() != 0) fail_count++;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tmo();
    fail_count++;
    close_out();
  endtask
  // Reads queue the expected byte first; the monitor owns the compare
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k = 0;
    if (!w) q.push_back({a, d});
    @(posedge REF_CLK);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I} <= {2'b11, w, a, 2'b00};
    WB_DAT_I <= {24'h0, d};
    do begin
      @(posedge REF_CLK);
      k++;
    end while (!WB_ACK_O && k < 50);
    {WB_CYC_I, WB_STB_I} <= 2'b00;
    if (!WB_ACK_O) tmo();
  endtask
  task automatic wirq();
    int k = 0;
    while (!IRQ && k < 2000) begin
      @(posedge REF_CLK);
      k++;
    end
    if (!IRQ) tmo();
  endtask
  task automatic pulse();
    @(posedge REF_CLK);
    CCP_TRIGGER <= 1;
    @(posedge REF_CLK);
    CCP_TRIGGER <= 0;
  endtask
  initial begin
    void'($urandom(75160));
    lvl[31:0] = $urandom;
    lvl[39:32] = 8'($urandom);
    PA_IN <= 6'($urandom);
    repeat (5) @(posedge REF_CLK);
    RST <= 0;
    bus(8'h85, 0, 8'h3f);
    bus(8'h1f, 0, 8'h00);
    bus(8'h0c, 0, 8'h00);
    bus(8'hff, 1, 8'h55);
    bus(8'hff, 0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      bus(8'h9f, 1, cf[i]);
      bus(8'h05, 0, {2'b00, PA_IN & mk[i]});
    end
    bus(8'h0b, 1, 8'hc0);
    bus(8'h8c, 1, 8'h40);
    // Bit periods here undercut the software minimum and RC runs awake:
    // the ideal comparator model needs no settling time
    for (int s = 0; s < 4; s++) begin
      c = s + (s == 3);
      e = {s[1:0], c[2:0], 3'b001};
      lo = h[s] * ((s == 3) ? 18 : 19);
      bus(8'h1f, 1, e);
      repeat (4) @(posedge REF_CLK);
      bus(8'h1f, 1, e | 8'h04);
      t0 = cyc_n;
      bus(8'h1f, 0, e | 8'h04);
      wirq();
      t0 = cyc_n - t0;
      ok = t0 >= lo && t0 <= 19 * h[s] + 3;
      `CHK("conv time", 1'b1, ok)
      bus(8'h1e, 0, lvl[c*8 +: 8]);
      bus(8'h1f, 0, e);
      bus(8'h0c, 0, 8'h40);
      bus(8'h0c, 1, 8'h40);
      repeat (4 * h[s]) @(posedge REF_CLK);
      `CHK("irq clear", 1'b0, IRQ)
    end
    bus(8'h1f, 1, 8'h00);
    bus(8'h20, 1, 8'h1b);
    repeat (10) @(posedge REF_CLK);
    bus(8'h20, 1, 8'h0b);
    bus(8'h21, 0, 8'h0d);
    pulse();
    bus(8'h21, 0, 8'h00);
    bus(8'h22, 0, 8'h00);
    bus(8'h1f, 0, 8'h00);
    bus(8'h8c, 1, 8'h00);
    bus(8'h1f, 1, 8'h19);
    repeat (4) @(posedge REF_CLK);
    pulse();
    bus(8'h1f, 0, 8'h1d);
    repeat (40) @(posedge REF_CLK);
    `CHK("irq masked", 1'b0, IRQ)
    bus(8'h1e, 0, lvl[31:24]);
    bus(8'h0c, 0, 8'h40);
    bus(8'h8c, 1, 8'h40);
    repeat (2) @(posedge REF_CLK);
    `CHK("irq set", 1'b1, IRQ)
    bus(8'h0c, 1, 8'h40);
    repeat (2) @(posedge REF_CLK);
    `CHK("irq off", 1'b0, IRQ)
    bus(8'h85, 1, 8'h3e);
    bus(8'h05, 1, 8'h01);
    bus(8'h1f, 1, 8'h05);
    wirq();
    bus(8'h1e, 0, 8'hff);
    close_out();
  end
endmodule
`default_nettype wire
